/* hdl/lrc_defs.svh */
// constants for the ladder reference control block
// assumes a 32-bit axi4-lite register bus and a 16-tap analog ladder outside
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define LRC_CTRL_OFFSET 8'h9f
`define LRC_CTRL_ADDR 12'h27c
`define LRC_ADDR_W 12
`define LRC_CTRL_RESET 8'h00
`define LRC_CTRL_WMASK 8'hef

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LRC_POWER_BIT 7
`define LRC_DRIVE_BIT 6
`define LRC_RANGE_BIT 5
`define LRC_TAP_MSB 3

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define LRC_RESP_OKAY 2'h0
`define LRC_RESP_SLVERR 2'h2

`endif

/* hdl/lrc_ladder_drive.sv */
// registered drive of the analog ladder controls
// assumes the control register contents arrive already reset-cleared
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_ladder_drive
	import lrc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire lrc_ctrl_s ctrl_in,
	input wire logic pin_dir_input_in,
	output lrc_ladder_s ladder_out
);
	lrc_ladder_s ladder_ff;
	lrc_ladder_s nxt_ladder;

	// ------------------------------------------------------------
	// ladder controls
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_ladder.ladder_power = ctrl_in.ladder_power_enable;
		nxt_ladder.pin_connect = ctrl_in.pin_drive_enable & pin_dir_input_in;
		nxt_ladder.range_select = ctrl_in.range_select;
		nxt_ladder.tap_code = ctrl_in.tap_code;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ladder_ff <= '0;
		else
			ladder_ff <= nxt_ladder;
	end

	assign ladder_out = ladder_ff;
endmodule

/* hdl/lrc_pkg.sv */
// types for the ladder reference control block
// assumes lrc_defs.svh for numbers
package lrc_pkg;
	typedef struct packed
	{
		logic ladder_power_enable;
		logic pin_drive_enable;
		logic range_select;
		logic unused_bit4;
		logic [3:0] tap_code;
	} lrc_ctrl_s;

	typedef struct packed
	{
		logic ladder_power;
		logic pin_connect;
		logic range_select;
		logic [3:0] tap_code;
	} lrc_ladder_s;
endpackage

/* hdl/lrc_top.sv */
// ladder reference control: axi4-lite slave with one control register
// assumes synchronous inputs on CLOCK_IN and an active-low asynchronous reset
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_top
	import lrc_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	input wire logic [31:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [31:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic PIN_DIR_INPUT_IN,
	output logic LADDER_POWER_OUT,
	output logic PIN_CONNECT_OUT,
	output logic RANGE_SELECT_OUT,
	output logic [3:0] TAP_CODE_OUT
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic addr_hit(input logic [31:0] a);
		logic word_hit;
		logic upper_clear;
		word_hit = a[`LRC_ADDR_W-1:2] == {2'h0, `LRC_CTRL_OFFSET};
		upper_clear = a[31:`LRC_ADDR_W] == '0;
		addr_hit = word_hit && upper_clear;
	endfunction

	function automatic logic [1:0] resp_code(input logic hit);
		resp_code = hit ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
	endfunction

	// bit 4 is not stored and always reads back as zero
	function automatic logic [7:0] reg_view(input lrc_ctrl_s c);
		reg_view = c & `LRC_CTRL_WMASK;
	endfunction

	// ------------------------------------------------------------
	// channel states and storage
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		WR_IDLE,
		WR_ADDR_HELD,
		WR_DATA_HELD,
		WR_COMMIT,
		WR_ANSWER
	} lrc_wr_state_e;

	typedef enum logic
	{
		RD_IDLE,
		RD_ANSWER
	} lrc_rd_state_e;

	lrc_wr_state_e wr_state_ff;
	lrc_wr_state_e nxt_wr_state;
	lrc_rd_state_e rd_state_ff;
	lrc_rd_state_e nxt_rd_state;
	lrc_ctrl_s ctrl_ff;
	lrc_ctrl_s nxt_ctrl;
	logic [31:0] awaddr_ff;
	logic [31:0] nxt_awaddr;
	logic [7:0] wdata_ff;
	logic [7:0] nxt_wdata;
	logic wstrb0_ff;
	logic nxt_wstrb0;
	logic [1:0] bresp_ff;
	logic [1:0] nxt_bresp;
	logic [1:0] rresp_ff;
	logic [1:0] nxt_rresp;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic b_done;
	logic r_done;
	logic commit;
	logic commit_hit;
	lrc_ladder_s ladder;

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	assign AWREADY_OUT = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_DATA_HELD);
	assign WREADY_OUT = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_ADDR_HELD);
	assign BVALID_OUT = wr_state_ff == WR_ANSWER;
	assign ARREADY_OUT = rd_state_ff == RD_IDLE;
	assign RVALID_OUT = rd_state_ff == RD_ANSWER;
	assign aw_fire = AWVALID_IN && AWREADY_OUT;
	assign w_fire = WVALID_IN && WREADY_OUT;
	assign ar_fire = ARVALID_IN && ARREADY_OUT;
	assign b_done = BVALID_OUT && BREADY_IN;
	assign r_done = RVALID_OUT && RREADY_IN;
	assign commit = wr_state_ff == WR_COMMIT;
	assign commit_hit = commit && addr_hit(awaddr_ff);
	assign BRESP_OUT = bresp_ff;
	assign RRESP_OUT = rresp_ff;
	assign RDATA_OUT = rdata_ff;

	// ------------------------------------------------------------
	// write sequencing
	// ------------------------------------------------------------
	// address and data may arrive in either order; the answer waits for both
	always_comb
	begin
		nxt_wr_state = wr_state_ff;
		unique case (wr_state_ff)
			WR_IDLE:
			begin
				if (aw_fire && w_fire)
					nxt_wr_state = WR_COMMIT;
				else if (aw_fire)
					nxt_wr_state = WR_ADDR_HELD;
				else if (w_fire)
					nxt_wr_state = WR_DATA_HELD;
			end
			WR_ADDR_HELD:
			begin
				if (w_fire)
					nxt_wr_state = WR_COMMIT;
			end
			WR_DATA_HELD:
			begin
				if (aw_fire)
					nxt_wr_state = WR_COMMIT;
			end
			WR_COMMIT:
			begin
				nxt_wr_state = WR_ANSWER;
			end
			WR_ANSWER:
			begin
				if (b_done)
					nxt_wr_state = WR_IDLE;
			end
			default:
			begin
				nxt_wr_state = WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			wr_state_ff <= WR_IDLE;
		else
			wr_state_ff <= nxt_wr_state;
	end

	// ------------------------------------------------------------
	// write address capture
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_awaddr = awaddr_ff;
		if (aw_fire)
			nxt_awaddr = AWADDR_IN;
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			awaddr_ff <= 32'h00000000;
		else
			awaddr_ff <= nxt_awaddr;
	end

	// ------------------------------------------------------------
	// write data capture
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_wdata = wdata_ff;
		nxt_wstrb0 = wstrb0_ff;
		if (w_fire)
		begin
			nxt_wdata = WDATA_IN[7:0];
			nxt_wstrb0 = WSTRB_IN[0];
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'h0;
		end
		else
		begin
			wdata_ff <= nxt_wdata;
			wstrb0_ff <= nxt_wstrb0;
		end
	end

	// ------------------------------------------------------------
	// write answer
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_bresp = bresp_ff;
		if (commit)
			nxt_bresp = resp_code(commit_hit);
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			bresp_ff <= 2'h0;
		else
			bresp_ff <= nxt_bresp;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (commit_hit && wstrb0_ff)
			nxt_ctrl = lrc_ctrl_s'(reg_view(lrc_ctrl_s'(wdata_ff)));
	end

	// no sleep input exists, so contents only change by write or reset
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			ctrl_ff <= `LRC_CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_rd_state = rd_state_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		unique case (rd_state_ff)
			RD_IDLE:
			begin
				if (ar_fire)
				begin
					nxt_rd_state = RD_ANSWER;
					nxt_rresp = resp_code(addr_hit(ARADDR_IN));
					if (addr_hit(ARADDR_IN))
						nxt_rdata = {24'h000000, reg_view(ctrl_ff)};
					else
						nxt_rdata = 32'h00000000;
				end
			end
			RD_ANSWER:
			begin
				if (r_done)
					nxt_rd_state = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			rd_state_ff <= RD_IDLE;
			rresp_ff <= 2'h0;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			rd_state_ff <= nxt_rd_state;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// ladder outputs
	// ------------------------------------------------------------
	lrc_ladder_drive u_drive
	(
		.clk_in(CLOCK_IN),
		.rst_b_in(RST_B_IN),
		.ctrl_in(ctrl_ff),
		.pin_dir_input_in(PIN_DIR_INPUT_IN),
		.ladder_out(ladder)
	);

	assign LADDER_POWER_OUT = ladder.ladder_power;
	assign PIN_CONNECT_OUT = ladder.pin_connect;
	assign RANGE_SELECT_OUT = ladder.range_select;
	assign TAP_CODE_OUT = ladder.tap_code;
endmodule

/* verification/lrc_top_monitor.sv */
// assertions on the ladder reference control top ports
// assumes binding onto lrc_top, port names matched one to one
`timescale 1ns/1ps
module lrc_top_monitor
(
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [1:0] RRESP_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic PIN_DIR_INPUT_IN,
	input wire logic LADDER_POWER_OUT,
	input wire logic PIN_CONNECT_OUT,
	input wire logic RANGE_SELECT_OUT,
	input wire logic [3:0] TAP_CODE_OUT
);
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	sequence wr_go;
		AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	endsequence
	sequence b_late;
		!BVALID_OUT ##1 BVALID_OUT;
	endsequence
	chk_write_answer:
	assert property (wr_go |=> b_late) else $error("write answer not on time");
	chk_read_answer:
	assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT) else $error("read answer late");
	chk_bvalid_hold:
	assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write answer dropped");
	chk_rvalid_hold:
	assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read answer dropped");
	chk_read_block:
	assert property (RVALID_OUT |-> !ARREADY_OUT) else $error("read taken while busy");
	chk_write_block:
	assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT) else $error("write taken busy");
	chk_read_zeros:
	assert property (RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0 && !RDATA_OUT[4])
		else $error("reserved read bits set");
	chk_pin_gate:
	assert property (PIN_CONNECT_OUT |-> $past(PIN_DIR_INPUT_IN)) else $error("pin joined as output");
	chk_ladder_cause:
	assert property ($changed({LADDER_POWER_OUT, RANGE_SELECT_OUT, TAP_CODE_OUT})
		|-> $past(BVALID_OUT) && !$past(BVALID_OUT, 2)) else $error("ladder moved without write");
endmodule
bind lrc_top lrc_top_monitor mon (.*);

/* verification/testbench.sv */
// self-checking bench for the ladder reference control block
// assumes lrc_top and its monitor compiled first
`timescale 1ns/1ps
`include "lrc_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
	logic CLOCK_IN, RST_B_IN, AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN;
	logic PIN_DIR_INPUT_IN;
	logic [31:0] AWADDR_IN, WDATA_IN, ARADDR_IN;
	logic [3:0] WSTRB_IN;
	wire AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
	wire LADDER_POWER_OUT, PIN_CONNECT_OUT, RANGE_SELECT_OUT;
	wire [1:0] BRESP_OUT, RRESP_OUT;
	wire [31:0] RDATA_OUT;
	wire [3:0] TAP_CODE_OUT;
	int err_count, tests_run, cyc, mreg;
	logic [31:0] adr;
	lrc_top dut (.*);
	initial
	begin
		CLOCK_IN = 0;
		forever #2.5 CLOCK_IN = ~CLOCK_IN;
	end
	always @(posedge CLOCK_IN)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			summarize();
		end
	end
	task summarize;
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function bit hit(input [31:0] a);
		return a[31:2] == {22'h0, `LRC_CTRL_OFFSET};
	endfunction
	task wr(input [31:0] a, input [7:0] d, input [3:0] s, input bit sl);
		bit ta, tw;
		@(posedge CLOCK_IN);
		AWADDR_IN <= a;
		AWVALID_IN <= 1;
		WDATA_IN <= {24'h0, d};
		WSTRB_IN <= s;
		WVALID_IN <= 1;
		BREADY_IN <= !sl;
		do
		begin
			@(negedge CLOCK_IN);
			ta = AWVALID_IN && AWREADY_OUT;
			tw = WVALID_IN && WREADY_OUT;
			@(posedge CLOCK_IN);
			if (ta) AWVALID_IN <= 0;
			if (tw) WVALID_IN <= 0;
		end while (AWVALID_IN || WVALID_IN);
		do @(negedge CLOCK_IN); while (!BVALID_OUT);
		if (sl)
		begin
			@(posedge CLOCK_IN);
			BREADY_IN <= 1;
			@(negedge CLOCK_IN);
		end
		`CHK(BRESP_OUT, hit(a) ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR)
		if (hit(a) && s[0]) mreg = d & `LRC_CTRL_WMASK;
		@(posedge CLOCK_IN);
		BREADY_IN <= 0;
	endtask
	task rd(input [31:0] a, input bit sl);
		@(posedge CLOCK_IN);
		ARADDR_IN <= a;
		ARVALID_IN <= 1;
		RREADY_IN <= !sl;
		do @(negedge CLOCK_IN); while (!ARREADY_OUT);
		@(posedge CLOCK_IN);
		ARVALID_IN <= 0;
		do @(negedge CLOCK_IN); while (!RVALID_OUT);
		if (sl)
		begin
			@(posedge CLOCK_IN);
			RREADY_IN <= 1;
			@(negedge CLOCK_IN);
		end
		`CHK(RRESP_OUT, hit(a) ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR)
		`CHK(RDATA_OUT, hit(a) ? 32'(mreg) : 32'h0)
		@(posedge CLOCK_IN);
		RREADY_IN <= 0;
	endtask
	task lad;
		@(negedge CLOCK_IN);
		`CHK({LADDER_POWER_OUT, PIN_CONNECT_OUT, RANGE_SELECT_OUT, TAP_CODE_OUT}, {mreg[7], mreg[6] & PIN_DIR_INPUT_IN, mreg[5], mreg[3:0]})
	endtask
	initial
	begin
		{AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN, PIN_DIR_INPUT_IN} = 0;
		{AWADDR_IN, WDATA_IN, ARADDR_IN, WSTRB_IN} = 0;
		{err_count, tests_run, cyc, mreg} = 0;
		RST_B_IN = 0;
		void'($urandom(32'h341a));
		repeat (6) @(posedge CLOCK_IN);
		RST_B_IN <= 1;
		lad();
		rd({20'h0, `LRC_CTRL_ADDR}, 0);
		for (int i = 0; i < 14; i++)
		begin
			PIN_DIR_INPUT_IN <= 1'($urandom);
			adr = (i % 5 == 4) ? 32'h280 : {20'h0, `LRC_CTRL_ADDR} + 32'(i & 3);
			wr(adr, i == 0 ? 8'hff : i == 1 ? 8'ha6 : 8'($urandom), i == 6 ? 4'he : 4'h1, i[0]);
			lad();
			repeat (2) @(posedge CLOCK_IN);
			rd(adr, i[1]);
			rd({20'h0, `LRC_CTRL_ADDR}, 0);
		end
		wr({20'h0, `LRC_CTRL_ADDR}, 8'($urandom) & 8'h7f, 4'h1, 0);
		lad();
		@(posedge CLOCK_IN);
		RST_B_IN <= 0;
		repeat (2) @(posedge CLOCK_IN);
		RST_B_IN <= 1;
		mreg = 0;
		lad();
		rd({20'h0, `LRC_CTRL_ADDR}, 0);
		summarize();
	end
endmodule
